// ---- inc/nghm_pkg.sv ----
// package of constants and types for the liveness supervision block
package nghm_pkg;
  // register indices (object numbers)
  localparam logic [15:0] REG_CONS_CFG = 16'h1016;
  localparam logic [15:0] REG_PROD_TIME = 16'h1017;
  localparam logic [15:0] REG_APP_FAULT = 16'h300B;
  localparam logic [15:0] REG_PWR_FAULT = 16'h300D;
  localparam logic [15:0] REG_GUARD_TIME = 16'h100C;
  localparam logic [15:0] REG_LIFE_FACTOR = 16'h100D;
  localparam logic [15:0] REG_CTRL = 16'h2066;
  localparam logic [15:0] REG_STATUS = 16'h2100;
  // reset values
  localparam logic [31:0] CONS_CFG_RST = 32'h0000_0000;
  localparam logic [15:0] PROD_TIME_RST = 16'h0000;
  localparam logic [15:0] GUARD_TIME_RST = 16'h0000;
  localparam logic [7:0] LIFE_FACTOR_RST = 8'h00;
  localparam logic [7:0] BUS_TMO_RST = 8'h00;
  // field positions
  localparam int CONS_TMO_LSB = 0;
  localparam int CONS_NODE_LSB = 16;
  localparam int TOGGLE_BIT = 7;
  localparam int APP_BUS_TMO_BIT = 20;
  localparam int CTRL_ACK_BIT = 8;
  // identifiers and state codes
  localparam logic [10:0] COB_GUARD_BASE = 11'h700;
  localparam logic [6:0] NODE_STATE_BOOT = 7'h00;
  localparam logic [6:0] NODE_STATE_STOPPED = 7'h04;
  localparam logic [6:0] NODE_STATE_OPER = 7'h05;
  localparam logic [6:0] NODE_STATE_PREOP = 7'h7F;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_TICK = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * MS_PER_TICK;
  localparam int HB_STEP_MS = 10;

  typedef enum {NS_BOOT, NS_PREOP, NS_OPER, NS_STOPPED} nghm_nmt_t;

  typedef struct packed {
    logic valid;
    logic rtr;
    logic [10:0] id;
    logic [7:0] data;
  } nghm_frame_t;
endpackage

// ---- hw/nghm_tick.sv ----
// millisecond tick generator
`timescale 1ns/10ps
module nghm_tick #(
  parameter int CYCLES = nghm_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_tick
);
  logic [31:0] cnt_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 32'h0000_0000;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  assign o_tick = (cnt_q == 32'(CYCLES - 1));
endmodule

// ---- hw/nghm_timer.sv ----
// restartable millisecond watchdog with expiry pulse
`timescale 1ns/10ps
module nghm_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_arm,
  input wire logic i_kick,
  input wire logic [23:0] i_limit,
  output logic o_expire
);
  logic [23:0] cnt_q;
  logic run_q;

  // limit of zero never expires
  assign o_expire = run_q && i_tick && i_arm && !i_kick
                    && (i_limit != 24'h00_0000)
                    && (cnt_q + 24'h00_0001 >= i_limit);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 24'h00_0000;
      run_q <= 1'b0;
    end else if (!i_arm) begin
      cnt_q <= 24'h00_0000;
      run_q <= 1'b0;
    end else if (i_kick) begin
      cnt_q <= 24'h00_0000;
      run_q <= 1'b1;
    end else if (o_expire) begin
      cnt_q <= 24'h00_0000;
      run_q <= 1'b0;
    end else if (run_q && i_tick) begin
      cnt_q <= cnt_q + 24'h00_0001;
    end
  end
endmodule

// ---- hw/nghm_top.sv ----
// node guarding and heartbeat liveness supervision
//
// Contract
// - answer query on 0x700+node, state+toggle
// - state codes 00,04,05,7F
// - guard time times life factor timeout raises error
// - bus timeout error acknowledgeable immediately
// - bus timeout stops running motor
// - producer and consumer enabled independently
// - no error unless bus timeout setting nonzero
// - producer active only when time nonzero
// - producer time counts ten millisecond steps
// - send heartbeat each period on 0x700+node
// - consumer low half is timeout ms
// - consumer bits 23..16 select node; the code decodes bits 22..16 only and ignores bit 23
// - consumer watches one node only
// - consumer supervision starts after first heartbeat
// - missing heartbeat raises error when enabled
// - application fault word fixed bit flags
// - power fault word fixed bit flags
// - guard time ms, factor counts periods
// - guarding supervision starts at first query
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module nghm_top #(
  parameter int TICK_CYCLES = nghm_pkg::TICK_CYCLES,
  parameter logic [6:0] NODE_ID = 7'h01
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire nghm_pkg::nghm_frame_t i_rx,
  output nghm_pkg::nghm_frame_t o_tx,
  input wire logic [1:0] i_nmt_state,
  input wire logic [31:0] i_app_faults,
  input wire logic [31:0] i_pwr_faults,
  input wire logic i_motor_running,
  output logic o_motor_stop,
  output logic o_error_state
);
  // ==========================================================
  // reset release
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ==========================================================
  // configuration registers
  logic [31:0] cons_cfg_q;
  logic [15:0] prod_time_q;
  logic [15:0] guard_time_q;
  logic [7:0] life_factor_q;
  logic [7:0] bus_tmo_q;
  logic bus_tmo_err_q;
  logic ack_w;

  assign ack_w = i_wr && (i_addr == nghm_pkg::REG_CTRL)
                 && i_wdata[nghm_pkg::CTRL_ACK_BIT];

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cons_cfg_q <= nghm_pkg::CONS_CFG_RST;
      prod_time_q <= nghm_pkg::PROD_TIME_RST;
      guard_time_q <= nghm_pkg::GUARD_TIME_RST;
      life_factor_q <= nghm_pkg::LIFE_FACTOR_RST;
      bus_tmo_q <= nghm_pkg::BUS_TMO_RST;
    end else if (i_wr) begin
      case (i_addr)
        nghm_pkg::REG_CONS_CFG: cons_cfg_q <= i_wdata;
        nghm_pkg::REG_PROD_TIME: prod_time_q <= i_wdata[15:0];
        nghm_pkg::REG_GUARD_TIME: guard_time_q <= i_wdata[15:0];
        nghm_pkg::REG_LIFE_FACTOR: life_factor_q <= i_wdata[7:0];
        nghm_pkg::REG_CTRL: bus_tmo_q <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // state code of this node
  logic [6:0] state_code;

  always_comb begin
    case (nghm_pkg::nghm_nmt_t'(i_nmt_state))
      nghm_pkg::NS_BOOT: state_code = nghm_pkg::NODE_STATE_BOOT;
      nghm_pkg::NS_PREOP: state_code = nghm_pkg::NODE_STATE_PREOP;
      nghm_pkg::NS_OPER: state_code = nghm_pkg::NODE_STATE_OPER;
      nghm_pkg::NS_STOPPED: state_code = nghm_pkg::NODE_STATE_STOPPED;
      default: state_code = nghm_pkg::NODE_STATE_PREOP;
    endcase
  end

  // ==========================================================
  // frame decode
  logic [10:0] own_id;
  logic [10:0] mon_id;
  logic guard_query;
  logic mon_hb;

  assign own_id = nghm_pkg::COB_GUARD_BASE + {4'h0, NODE_ID};
  assign mon_id = nghm_pkg::COB_GUARD_BASE
                  + {4'h0, cons_cfg_q[nghm_pkg::CONS_NODE_LSB +: 7]};
  // only remote frames count as queries
  assign guard_query = i_rx.valid && i_rx.rtr && (i_rx.id == own_id);
  assign mon_hb = i_rx.valid && !i_rx.rtr && (i_rx.id == mon_id);

  // ==========================================================
  // millisecond tick
  logic tick_ms;

  nghm_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .o_tick(tick_ms)
  );

  // ==========================================================
  // node guarding supervision
  logic guard_on;
  logic [23:0] guard_limit;
  logic guard_exp;

  assign guard_on = (guard_time_q != 16'h0000)
                    && (life_factor_q != 8'h00);
  assign guard_limit = {8'h00, guard_time_q} * {16'h0000, life_factor_q};

  // armed timer starts on first query
  nghm_timer u_guard_tmr (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_tick(tick_ms),
    .i_arm(guard_on),
    .i_kick(guard_query),
    .i_limit(guard_limit),
    .o_expire(guard_exp)
  );

  // ==========================================================
  // heartbeat consumer
  logic cons_on;
  logic cons_exp;

  assign cons_on = (cons_cfg_q[nghm_pkg::CONS_TMO_LSB +: 16] != 16'h0000);

  nghm_timer u_cons_tmr (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_tick(tick_ms),
    .i_arm(cons_on),
    .i_kick(mon_hb),
    .i_limit({8'h00, cons_cfg_q[nghm_pkg::CONS_TMO_LSB +: 16]}),
    .o_expire(cons_exp)
  );

  // ==========================================================
  // heartbeat producer
  logic [23:0] prod_ms_q;
  logic prod_fire;

  assign prod_fire = (prod_time_q != 16'h0000) && tick_ms
    && (prod_ms_q + 24'h00_0001
        >= 24'(prod_time_q * nghm_pkg::HB_STEP_MS));

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prod_ms_q <= 24'h00_0000;
    end else if (prod_time_q == 16'h0000 || prod_fire) begin
      prod_ms_q <= 24'h00_0000;
    end else if (tick_ms) begin
      prod_ms_q <= prod_ms_q + 24'h00_0001;
    end
  end

  // ==========================================================
  // transmit path
  logic toggle_q;

  // toggle begins low, flips per reply
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_q <= 1'b0;
    end else if (guard_query) begin
      toggle_q <= ~toggle_q;
    end
  end

  // query reply wins; heartbeat waits for the first cycle without a query
  logic hb_pend_q;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_pend_q <= 1'b0;
    end else begin
      hb_pend_q <= (prod_fire || hb_pend_q) && guard_query;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx <= '0;
    end else if (guard_query) begin
      o_tx.valid <= 1'b1;
      o_tx.rtr <= 1'b0;
      o_tx.id <= own_id;
      o_tx.data <= {toggle_q, state_code};
    end else if (prod_fire || hb_pend_q) begin
      o_tx.valid <= 1'b1;
      o_tx.rtr <= 1'b0;
      o_tx.id <= own_id;
      o_tx.data <= {1'b0, state_code};
    end else begin
      o_tx.valid <= 1'b0;
    end
  end

  // ==========================================================
  // bus timeout error
  logic tmo_set;

  assign tmo_set = (bus_tmo_q != 8'h00) && (guard_exp || cons_exp);

  // ack accepted any time; new timeout wins
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_tmo_err_q <= 1'b0;
    end else if (tmo_set) begin
      bus_tmo_err_q <= 1'b1;
    end else if (ack_w) begin
      bus_tmo_err_q <= 1'b0;
    end
  end

  assign o_error_state = bus_tmo_err_q;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_motor_stop <= 1'b0;
    end else begin
      o_motor_stop <= (tmo_set || bus_tmo_err_q) && i_motor_running;
    end
  end

  // ==========================================================
  // read path
  logic [31:0] app_word;

  // bus timeout flag on its fixed bit
  always_comb begin
    app_word = i_app_faults;
    app_word[nghm_pkg::APP_BUS_TMO_BIT] = bus_tmo_err_q;
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        nghm_pkg::REG_CONS_CFG: o_rdata <= cons_cfg_q;
        nghm_pkg::REG_PROD_TIME: o_rdata <= {16'h0000, prod_time_q};
        nghm_pkg::REG_GUARD_TIME: o_rdata <= {16'h0000, guard_time_q};
        nghm_pkg::REG_LIFE_FACTOR: o_rdata <= {24'h00_0000, life_factor_q};
        nghm_pkg::REG_CTRL: o_rdata <= {24'h00_0000, bus_tmo_q};
        nghm_pkg::REG_APP_FAULT: o_rdata <= app_word;
        // power faults passed bit for bit
        nghm_pkg::REG_PWR_FAULT: o_rdata <= i_pwr_faults;
        nghm_pkg::REG_STATUS: o_rdata <= {29'h0, guard_on, cons_on,
                                          bus_tmo_err_q};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  property p_reply;
    @(posedge i_ref_clk) disable iff (!rst_n)
    guard_query |=> o_tx.valid && !o_tx.rtr && o_tx.id == own_id
      && o_tx.data[nghm_pkg::TOGGLE_BIT] == $past(toggle_q);
  endproperty
  a_reply: assert property (p_reply) else $error("bad guard reply");
  property p_toggle;
    @(posedge i_ref_clk) disable iff (!rst_n)
    guard_query |=> toggle_q != $past(toggle_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle stuck");
  property p_gate;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (bus_tmo_q == 8'h00 && !bus_tmo_err_q) |=> !bus_tmo_err_q;
  endproperty
  a_gate: assert property (p_gate) else $error("error while off");
  property p_guard_err;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (guard_exp && bus_tmo_q != 8'h00) |=> bus_tmo_err_q;
  endproperty
  a_guard_err: assert property (p_guard_err) else $error("no guard err");
  property p_cons_err;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (cons_exp && bus_tmo_q != 8'h00) |=> bus_tmo_err_q;
  endproperty
  a_cons_err: assert property (p_cons_err) else $error("no hb err");
  property p_ack;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (ack_w && !tmo_set) |=> !bus_tmo_err_q;
  endproperty
  a_ack: assert property (p_ack) else $error("ack ignored");
  sequence s_err_run;
    bus_tmo_err_q && i_motor_running;
  endsequence
  property p_stop;
    @(posedge i_ref_clk) disable iff (!rst_n)
    s_err_run |=> o_motor_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("motor not stopped");
  property p_prod_off;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (prod_time_q == 16'h0000 && !guard_query && !hb_pend_q)
      |=> !o_tx.valid;
  endproperty
  a_prod_off: assert property (p_prod_off) else $error("hb while off");
  property p_hb;
    @(posedge i_ref_clk) disable iff (!rst_n)
    (prod_fire && !guard_query) |=> o_tx.valid && o_tx.id == own_id
      && o_tx.data == {1'b0, $past(state_code)};
  endproperty
  a_hb: assert property (p_hb) else $error("bad heartbeat");
  property p_cons_start;
    @(posedge i_ref_clk) disable iff (!rst_n)
    !cons_on |=> !cons_exp;
  endproperty
  a_cons_start: assert property (p_cons_start) else $error("early hb");
endmodule

// ---- tb/nghm_bus_peer.sv ----
// bus peer model: guarding master and monitored heartbeat node
`timescale 1ns/10ps
module nghm_bus_peer #(
  parameter logic [6:0] NODE_ID = 7'h01
) (
  input wire logic i_clk,
  output nghm_pkg::nghm_frame_t o_frame
);
  logic pend = 1'b0;
  nghm_pkg::nghm_frame_t nxt;
  initial o_frame = '0;
  // ==========================================
  // frame launch
  // idle fields scramble so stale data never looks valid
  always @(posedge i_clk) begin
    if (pend) begin
      o_frame <= nxt;
      pend <= 1'b0;
    end else begin
      o_frame <= {1'b0, ~o_frame[19:0]};
    end
  end
  task automatic send(input nghm_pkg::nghm_frame_t f);
    @(negedge i_clk);
    nxt = f;
    pend = 1'b1;
    @(posedge i_clk);
    #1;
  endtask
  task automatic query();
    send({2'b11, nghm_pkg::COB_GUARD_BASE + {4'h0, NODE_ID}, 8'h00});
  endtask
  task automatic heartbeat(input logic [6:0] node);
    send({2'b10, nghm_pkg::COB_GUARD_BASE + {4'h0, node}, 8'h05});
  endtask
endmodule

// ---- tb/tb_nghm_top.sv ----
// self-checking bench for the liveness supervision block
`timescale 1ns/10ps
module tb_nghm_top;
  // short millisecond keeps timeouts to a few dozen cycles
  localparam int TC = 10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  nghm_pkg::nghm_frame_t rx;
  nghm_pkg::nghm_frame_t tx;
  logic [1:0] nmt = 2'h1;
  logic [31:0] app_f = 32'h0200_0001;
  logic [31:0] pwr_f = 32'h0020_0081;
  logic run = 1'b1;
  logic stop;
  logic err;
  int miscompares = 0;
  int samples_checked = 0;
  logic tgl = 1'b0;
  int n;

  always #10 clk = ~clk;

  nghm_top #(.TICK_CYCLES(TC), .NODE_ID(7'h01)) DUT (
    .i_ref_clk(clk),
    .i_rstn(rstn),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr),
    .i_rd(rd),
    .o_rdata(rdata),
    .i_rx(rx),
    .o_tx(tx),
    .i_nmt_state(nmt),
    .i_app_faults(app_f),
    .i_pwr_faults(pwr_f),
    .i_motor_running(run),
    .o_motor_stop(stop),
    .o_error_state(err)
  );
  nghm_bus_peer #(.NODE_ID(7'h01)) PEER (.i_clk(clk), .o_frame(rx));

  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e,
                      input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wait_err(input int mx);
    n = 0;
    while (err !== 1'b1 && n < mx) begin
      idle(1);
      n++;
    end
  endtask
  task automatic wait_tx(input int mx);
    n = 0;
    do begin
      idle(1);
      n++;
    end while (tx.valid !== 1'b1 && n < mx);
  endtask
  task automatic guard_query(input logic [6:0] code);
    PEER.query();
    wait_tx(3);
    chk("reply valid", 32'h1, {31'h0, tx.valid});
    chk("reply rtr", 32'h0, {31'h0, tx.rtr});
    chk("reply id", 32'h701, {21'h0, tx.id});
    chk("reply data", {24'h0, tgl, code}, {24'h0, tx.data});
    tgl = ~tgl;
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs();
    rchk(16'h1016, 32'h0, "cons cfg rst");
    rchk(16'h1017, 32'h0, "prod time rst");
    rchk(16'h1234, 32'h0, "unmapped");
    wr_reg(16'h300D, 32'hFFFF_FFFF);
    rchk(16'h300D, 32'h0020_0081, "pwr word");
    rchk(16'h300B, 32'h0200_0001, "app word");
    wr_reg(16'h1016, 32'h0012_3456);
    rchk(16'h1016, 32'h0012_3456, "cons cfg rw");
    wr_reg(16'h1016, 32'h0);
  endtask
  task automatic t_reply();
    logic [6:0] codes [4] = '{7'h00, 7'h7F, 7'h05, 7'h04};
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      nmt <= 2'(s);
      guard_query(codes[s]);
    end
    @(posedge clk);
    nmt <= 2'h1;
  endtask
  task automatic t_guard();
    wr_reg(16'h100C, 32'h2);
    wr_reg(16'h100D, 32'h2);
    wr_reg(16'h2066, 32'h1);
    idle(80);
    chk("err before query", 32'h0, {31'h0, err});
    wr_reg(16'h2066, 32'h0);
    guard_query(7'h7F);
    idle(80);
    chk("err disabled", 32'h0, {31'h0, err});
    wr_reg(16'h2066, 32'h1);
    guard_query(7'h7F);
    idle(25);
    chk("guard early", 32'h0, {31'h0, err});
    wait_err(60);
    chk("guard tmo", 32'h1, {31'h0, err});
    idle(1);
    chk("motor stop", 32'h1, {31'h0, stop});
    rchk(16'h2100, 32'h5, "status");
    rchk(16'h100C, 32'h2, "guard time");
    rchk(16'h100D, 32'h2, "life factor");
    rchk(16'h2066, 32'h1, "tmo enable");
    rchk(16'h300B, 32'h0210_0001, "app bus tmo");
    wr_reg(16'h2066, 32'h101);
    idle(2);
    chk("guard ack", 32'h0, {30'h0, stop, err});
    wr_reg(16'h100C, 32'h0);
    wr_reg(16'h100D, 32'h0);
    guard_query(7'h7F);
    idle(80);
    chk("guard off", 32'h0, {31'h0, err});
  endtask
  task automatic t_consumer();
    @(posedge clk);
    run <= 1'b0;
    wr_reg(16'h1016, 32'h0005_0003);
    idle(80);
    chk("cons before hb", 32'h0, {31'h0, err});
    PEER.heartbeat(7'h06);
    idle(80);
    chk("other node", 32'h0, {31'h0, err});
    PEER.heartbeat(7'h05);
    idle(15);
    chk("cons early", 32'h0, {31'h0, err});
    wait_err(60);
    chk("cons tmo", 32'h1, {31'h0, err});
    chk("stop idle motor", 32'h0, {31'h0, stop});
    @(posedge clk);
    run <= 1'b1;
    idle(2);
    chk("stop cons", 32'h1, {31'h0, stop});
    wr_reg(16'h2066, 32'h101);
    idle(2);
    chk("cons ack", 32'h0, {30'h0, stop, err});
    wr_reg(16'h1016, 32'h0);
  endtask
  task automatic t_producer();
    @(posedge clk);
    nmt <= 2'h2;
    wr_reg(16'h1017, 32'h1);
    wait_tx(130);
    chk("hb id", 32'h701, {21'h0, tx.id});
    chk("hb data", 32'h05, {24'h0, tx.data});
    wait_tx(130);
    chk("hb period", 32'd100, 32'(n));
    wr_reg(16'h1017, 32'h0);
    wait_tx(130);
    chk("hb off", 32'd130, 32'(n));
  endtask

  // ==========================================
  // verdict
  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_reply();
    t_guard();
    t_consumer();
    t_producer();
    final_report();
  end
endmodule
